/* csil_pkg.sv */
// constants shared by the charger status device end and the host end
// assumes a 20 MHz system clock; registers are reached over the link
package csil_pkg;
	// clock and timing
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned ALERT_US = 256;
	localparam int unsigned ALERT_CYC = ALERT_US * CLK_MHZ;
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned BLINK_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int unsigned STEP_MS = 100;
	localparam int unsigned STEP_CYC = STEP_MS * 1000 * CLK_MHZ;
	localparam int unsigned SETTLE_US = 10;
	localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
	// register indices on the link
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_LIMIT = 2'h1;
	localparam logic [1:0] REG_FAULT = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	// control register fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_RAISE = 1;
	localparam int CTL_LOWER = 2;
	localparam int CTL_IND_DIS = 3;
	localparam int CTL_LIM_PIN = 4;
	localparam int CTL_DPM_MASK = 5;
	localparam logic [7:0] CTL_REQ_MASK = 8'h06;
	localparam logic [7:0] CTL_EN_MASK = 8'h01;
	// values
	localparam logic [5:0] LIMIT_RESET = 6'h08;
	localparam logic [5:0] LIMIT_100MA = 6'h00;
	localparam logic [7:0] FAULT_REFUSED = 8'hff;
	localparam logic [2:0] RAISE_PULSES = 3'h3;
	localparam logic [2:0] LOWER_PULSES = 3'h2;
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_LOW = 2'b01,
		PS_PROG = 2'b10
	} csil_pump_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_PREP = 2'b01,
		HS_ISSUE = 2'b10,
		HS_WAIT = 2'b11
	} csil_host_t;
endpackage

/* csil_link_if.sv */
// link between the charger status device end and the host end
// both ends run on the same clk_sys; the testbench joins them here
`timescale 1ns/100ps
interface csil_link_if;
	logic power_good_pin_n;
	logic host_alert_pin_n;
	logic acc_req;
	logic acc_write;
	logic acc_burst;
	logic [1:0] acc_addr;
	logic [7:0] acc_wdata;
	logic acc_ack;
	logic [7:0] acc_rdata;
	modport dev (
		output power_good_pin_n, host_alert_pin_n, acc_ack, acc_rdata,
		input acc_req, acc_write, acc_burst, acc_addr, acc_wdata
	);
	modport host (
		input power_good_pin_n, host_alert_pin_n, acc_ack, acc_rdata,
		output acc_req, acc_write, acc_burst, acc_addr, acc_wdata
	);
endinterface

/* csil_tick.sv */
// enable divider: one-cycle tick every PERIOD cycles while run is high
// assumes run drops between uses so each use starts a fresh period
`timescale 1ns/100ps
module csil_tick import csil_pkg::*; #(
	parameter int unsigned PERIOD = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// control
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);
	logic [W-1:0] cnt;
	wire logic at_last = (cnt == LAST);
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !run) begin
			cnt <= '0;
			tick <= 1'h0;
		end else begin
			cnt <= at_last ? '0 : cnt + 1'h1;
			tick <= at_last;
		end
	end
endmodule

/* csil_device.sv */
// charger status, alert and current-pulse logic of the device end
// analog sensing arrives as synchronous comparator levels
// How it works
// - good source sets flag, pulls pin low
// - good needs window, awake, poor check, detection
// - test load applied, input must stay above minimum
// - indicator low while charging or recharging
// - indicator released when done, disabled or asleep
// - suspended charging blinks indicator at 1 Hz
// - disable bit stops indicator driving
// - each state update gives or joins a 256 us low alert
// - faults, done, identify, good enter/leave alert
// - regulation entry alerts, maskable by software
// - fault gives one alert, bits recorded
// - fault bits held until register read
// - no fault alert until read and cleared
// - read returns history then clears; read twice
// - fault register single transfers only
// - host sets protocol enable before requests
// - host sets raise or lower, never both
// - busy bit held, limit alternates with 100 mA
// - end restores limit, clears request bit
// - enable cleared mid-sequence aborts at once
// - requests ignored while protocol disabled
// - pin enabled applies lower limit, else register
`timescale 1ns/100ps
module csil_device import csil_pkg::*; #(
	parameter int unsigned ALERT_CYCLES = ALERT_CYC,
	parameter int unsigned BLINK_CYCLES = BLINK_CYC,
	parameter int unsigned STEP_CYCLES = STEP_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// host link
	csil_link_if.dev link,
	// input source comparators
	input wire logic vbus_in_window,
	input wire logic vbus_above_battery,
	input wire logic vbus_above_min,
	input wire logic type_detect_done,
	input wire logic source_identified,
	// charger state
	input wire logic charging,
	input wire logic charge_done,
	input wire logic charge_suspended,
	input wire logic [7:0] fault_active,
	input wire logic dpm_active,
	input wire logic [5:0] limit_resistor_pin,
	// outputs to the power stage and indicator
	output logic test_load_en,
	output logic [5:0] applied_limit,
	output logic limit_monitor_en,
	output logic stat_pin_o,
	output logic stat_pin_oe
);
	// control register
	logic pulse_protocol_enable;
	logic raise_request;
	logic lower_request;
	logic indicator_disable;
	logic limit_pin_enable;
	logic dpm_alert_mask;
	logic [5:0] input_limit_setting;
	logic [7:0] fault_register;
	logic fault_armed;
	logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt;
	logic poor_ok;
	logic source_good_flag;
	logic done_q;
	logic ident_q;
	logic dpm_q;
	logic blink_q;
	logic [$clog2(ALERT_CYCLES+1)-1:0] alert_cnt;
	csil_pump_t pump_state;
	logic [2:0] pulse_cnt;
	logic blink_tick;
	logic step_tick;

	localparam logic [$clog2(SETTLE_CYC+1)-1:0] SETTLE_LAST =
		($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1);
	localparam logic [$clog2(ALERT_CYCLES+1)-1:0] ALERT_LOAD =
		($clog2(ALERT_CYCLES+1))'(ALERT_CYCLES);

	// register access decode
	wire logic acc_rd = link.acc_req & ~link.acc_write;
	wire logic acc_wr = link.acc_req & link.acc_write;
	wire logic is_fault = (link.acc_addr == REG_FAULT);
	wire logic fault_read = acc_rd & is_fault & ~link.acc_burst;
	wire logic ctrl_wr = acc_wr & (link.acc_addr == REG_CTRL);
	wire logic limit_wr = acc_wr & (link.acc_addr == REG_LIMIT);
	wire logic wr_raise = link.acc_wdata[CTL_RAISE];
	wire logic wr_lower = link.acc_wdata[CTL_LOWER];
	wire logic pump_busy = (pump_state != PS_IDLE);
	// one-hot request, only with the protocol already on and idle
	wire logic pump_start = ctrl_wr & pulse_protocol_enable & ~pump_busy &
		(wr_raise ^ wr_lower);
	wire logic pump_abort = pump_busy & ~pulse_protocol_enable;
	wire logic [2:0] pulse_last = raise_request ? RAISE_PULSES :
		LOWER_PULSES;
	wire logic pump_end = (pump_state == PS_PROG) & step_tick &
		(pulse_cnt == pulse_last);

	// source qualification
	wire logic source_window = vbus_in_window & vbus_above_battery;
	wire logic next_good = source_window & poor_ok & type_detect_done;

	// alert sources
	wire logic ev_fault = fault_armed & (|fault_active);
	wire logic ev_done = charge_done & ~done_q;
	wire logic ev_ident = source_identified & ~ident_q;
	wire logic ev_good = next_good ^ source_good_flag;
	wire logic ev_dpm = dpm_active & ~dpm_q & ~dpm_alert_mask;
	wire logic any_event = ev_fault | ev_done | ev_ident | ev_good | ev_dpm;

	// limit selection
	wire logic pin_lower = limit_resistor_pin < input_limit_setting;
	wire logic [5:0] base_limit = (limit_pin_enable & pin_lower) ?
		limit_resistor_pin : input_limit_setting;

	// indicator: blink beats steady, disable beats both
	wire logic ind_low = charge_suspended ? blink_q : charging;
	wire logic next_stat_oe = ~indicator_disable & ind_low;

	wire logic [7:0] ctrl_rd = {2'h0, dpm_alert_mask, limit_pin_enable,
		indicator_disable, lower_request, raise_request,
		pulse_protocol_enable};
	wire logic [7:0] status_rd = {3'h0, charge_done, charging, pump_busy,
		poor_ok, source_good_flag};
	wire logic [7:0] fault_rd = link.acc_burst ? FAULT_REFUSED :
		fault_register;
	wire logic [7:0] next_rdata = (link.acc_addr == REG_CTRL) ? ctrl_rd :
		(link.acc_addr == REG_LIMIT) ? {2'h0, input_limit_setting} :
		is_fault ? fault_rd : status_rd;

	csil_tick #(.PERIOD(BLINK_CYCLES)) u_blink (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(charge_suspended),
		.tick(blink_tick)
	);

	csil_tick #(.PERIOD(STEP_CYCLES)) u_step (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(pump_busy),
		.tick(step_tick)
	);

	// bus answer one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			link.acc_ack <= 1'h0;
			link.acc_rdata <= 8'h00;
		end else begin
			link.acc_ack <= link.acc_req;
			link.acc_rdata <= acc_rd ? next_rdata : 8'h00;
		end
	end

	// control and limit registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pulse_protocol_enable <= 1'h0;
			indicator_disable <= 1'h0;
			limit_pin_enable <= 1'h1;
			dpm_alert_mask <= 1'h0;
			input_limit_setting <= LIMIT_RESET;
		end else begin
			if (ctrl_wr) begin
				pulse_protocol_enable <= link.acc_wdata[CTL_ENABLE];
				indicator_disable <= link.acc_wdata[CTL_IND_DIS];
				limit_pin_enable <= link.acc_wdata[CTL_LIM_PIN];
				dpm_alert_mask <= link.acc_wdata[CTL_DPM_MASK];
			end
			if (limit_wr) begin
				input_limit_setting <= link.acc_wdata[5:0];
			end
		end
	end

	// poor-source check: load on, settle, then sample the comparator
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !source_window) begin
			settle_cnt <= '0;
			poor_ok <= 1'h0;
			test_load_en <= 1'h0;
		end else if (!poor_ok) begin
			test_load_en <= 1'h1;
			if (test_load_en && settle_cnt == SETTLE_LAST) begin
				settle_cnt <= '0;
				poor_ok <= vbus_above_min;
				test_load_en <= ~vbus_above_min;
			end else begin
				settle_cnt <= settle_cnt + 1'h1;
			end
		end else begin
			test_load_en <= 1'h0;
		end
	end

	// power good, edge history and indicator
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			source_good_flag <= 1'h0;
			link.power_good_pin_n <= 1'h1;
			done_q <= 1'h0;
			ident_q <= 1'h0;
			dpm_q <= 1'h0;
			blink_q <= 1'h0;
			stat_pin_o <= 1'h0;
			stat_pin_oe <= 1'h0;
			limit_monitor_en <= 1'h0;
		end else begin
			source_good_flag <= next_good;
			link.power_good_pin_n <= ~next_good;
			done_q <= charge_done;
			ident_q <= source_identified;
			dpm_q <= dpm_active;
			blink_q <= charge_suspended & (blink_q ^ blink_tick);
			stat_pin_o <= 1'h0;
			stat_pin_oe <= next_stat_oe;
			// monitoring only exists with the pin function on
			limit_monitor_en <= limit_pin_enable;
		end
	end

	// fault history: a fault arriving in the read cycle survives
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fault_register <= 8'h00;
			fault_armed <= 1'h1;
		end else begin
			fault_register <= fault_read ? fault_active :
				(fault_register | fault_active);
			if (ev_fault) begin
				fault_armed <= 1'h0;
			end else if (fault_register == 8'h00) begin
				fault_armed <= 1'h1;
			end
		end
	end

	// alert pulse; events during a pulse merge into it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			alert_cnt <= '0;
			link.host_alert_pin_n <= 1'h1;
		end else if (alert_cnt == '0) begin
			if (any_event) begin
				alert_cnt <= ALERT_LOAD;
				link.host_alert_pin_n <= 1'h0;
			end
		end else begin
			alert_cnt <= alert_cnt - 1'h1;
			link.host_alert_pin_n <= (alert_cnt ==
				($clog2(ALERT_CYCLES+1))'(1));
		end
	end

	// current-pulse sequencer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pump_state <= PS_IDLE;
			pulse_cnt <= 3'h0;
			raise_request <= 1'h0;
			lower_request <= 1'h0;
			applied_limit <= LIMIT_RESET;
		end else begin
			case (pump_state)
			PS_IDLE: begin
				if (pump_start) begin
					raise_request <= wr_raise;
					lower_request <= wr_lower;
					pulse_cnt <= 3'h1;
					pump_state <= PS_LOW;
				end
			end
			PS_LOW: begin
				if (step_tick) begin
					pump_state <= PS_PROG;
				end
			end
			PS_PROG: begin
				if (pump_end) begin
					pump_state <= PS_IDLE;
					raise_request <= 1'h0;
					lower_request <= 1'h0;
				end else if (step_tick) begin
					pulse_cnt <= pulse_cnt + 3'h1;
					pump_state <= PS_LOW;
				end
			end
			default: begin
				pump_state <= PS_IDLE;
			end
			endcase
			if (pump_abort) begin
				pump_state <= PS_IDLE;
				raise_request <= 1'h0;
				lower_request <= 1'h0;
			end
			applied_limit <= (pump_state == PS_LOW && !pump_abort) ?
				LIMIT_100MA : base_limit;
		end
	end
endmodule

/* csil_host.sv */
// host end: turns user commands into link accesses and watches the pins
// assumes the device answers each request with acc_ack a cycle later
`timescale 1ns/100ps
module csil_host import csil_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// device link
	csil_link_if.host link,
	// user commands
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_burst,
	input wire logic [1:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	// user answers
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic [7:0] rsp_active,
	// pin watch
	output logic alert_event,
	output logic power_good
);
	csil_host_t state;
	logic c_write;
	logic c_burst;
	logic [1:0] c_addr;
	logic [7:0] c_wdata;
	logic prep;
	logic second;
	logic shadow_en;
	logic alert_q;

	wire logic c_fault = (c_addr == REG_FAULT);
	wire logic in_fault = (cmd_addr == REG_FAULT);
	wire logic in_ctrl = cmd_write & (cmd_addr == REG_CTRL);
	wire logic in_req = |(cmd_wdata & CTL_REQ_MASK);
	wire logic in_both = cmd_wdata[CTL_RAISE] & cmd_wdata[CTL_LOWER];
	// keep raise when both are asked for
	wire logic [7:0] fix_data = in_both ?
		(cmd_wdata & ~(CTL_REQ_MASK & ~(8'h01 << CTL_RAISE))) :
		cmd_wdata;
	wire logic [7:0] req_data = (in_ctrl & in_req) ?
		(fix_data | CTL_EN_MASK) : cmd_wdata;
	wire logic need_prep = in_ctrl & in_req & ~shadow_en;
	wire logic take = cmd_valid & (state == HS_IDLE);
	wire logic done_one = (state == HS_WAIT) & link.acc_ack;
	wire logic again = done_one & ~c_write & c_fault & ~second;

	assign cmd_ready = (state == HS_IDLE);
	assign link.acc_req = (state == HS_ISSUE) | (state == HS_PREP);
	assign link.acc_write = prep | c_write;
	assign link.acc_burst = c_burst;
	assign link.acc_addr = prep ? REG_CTRL : c_addr;
	assign link.acc_wdata = prep ? (c_wdata & ~CTL_REQ_MASK) : c_wdata;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= HS_IDLE;
			c_write <= 1'h0;
			c_burst <= 1'h0;
			c_addr <= REG_CTRL;
			c_wdata <= 8'h00;
			prep <= 1'h0;
			second <= 1'h0;
		end else begin
			case (state)
			HS_IDLE: begin
				if (take) begin
					c_write <= cmd_write;
					c_burst <= cmd_burst & ~in_fault;
					c_addr <= cmd_addr;
					c_wdata <= req_data;
					prep <= need_prep;
					second <= 1'h0;
					state <= need_prep ? HS_PREP : HS_ISSUE;
				end
			end
			HS_PREP: begin
				state <= HS_WAIT;
			end
			HS_ISSUE: begin
				state <= HS_WAIT;
			end
			HS_WAIT: begin
				if (link.acc_ack) begin
					prep <= 1'h0;
					if (prep || again) begin
						second <= ~prep;
						state <= HS_ISSUE;
					end else begin
						state <= HS_IDLE;
					end
				end
			end
			default: begin
				state <= HS_IDLE;
			end
			endcase
		end
	end

	// answers and pin watch
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rsp_valid <= 1'h0;
			rsp_data <= 8'h00;
			rsp_active <= 8'h00;
			shadow_en <= 1'h0;
			alert_q <= 1'h1;
			alert_event <= 1'h0;
			power_good <= 1'h0;
		end else begin
			rsp_valid <= done_one & ~prep & ~again;
			if (done_one && !prep && !second) begin
				rsp_data <= link.acc_rdata;
			end
			if (done_one && second) begin
				rsp_active <= link.acc_rdata;
			end
			if (done_one && link.acc_write && link.acc_addr == REG_CTRL) begin
				shadow_en <= link.acc_wdata[CTL_ENABLE];
			end
			alert_q <= link.host_alert_pin_n;
			alert_event <= alert_q & ~link.host_alert_pin_n;
			power_good <= ~link.power_good_pin_n;
		end
	end
endmodule

/* csil_link_monitor.sv */
// checker for the link between the device end and the host end
// assumes one clk_sys domain with a synchronous active-high reset
`timescale 1ns/100ps
module csil_link_monitor import csil_pkg::*; #(
	parameter int unsigned ALERT_CYCLES = ALERT_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins
	input wire logic power_good_pin_n,
	input wire logic host_alert_pin_n,
	// register access
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic acc_burst,
	input wire logic [1:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_ack,
	input wire logic [7:0] acc_rdata
);
	logic [15:0] low_cnt;
	logic [15:0] next_low_cnt;
	logic fb_rd;
	assign fb_rd = acc_req & ~acc_write & acc_burst & (acc_addr == REG_FAULT);
	// a counter, because a pulse this long cannot be a repetition
	assign next_low_cnt = host_alert_pin_n ? 16'h0000 : low_cnt + 16'h0001;
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			low_cnt <= 16'h0000;
		else
			low_cnt <= next_low_cnt;
	end
	default clocking mon_clk @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	property refused_p;
		fb_rd |=> acc_rdata == FAULT_REFUSED;
	endproperty
	property alert_w_p;
		$rose(host_alert_pin_n) |-> low_cnt == 16'(ALERT_CYCLES);
	endproperty
	// a change seen while no pulse ran must start one on the same edge
	property good_alert_p;
		$changed(power_good_pin_n) && $past(host_alert_pin_n)
			|-> !host_alert_pin_n;
	endproperty
	ack_timing_a: assert property (acc_req |=> acc_ack)
		else $error("no ack after request");
	ack_cause_a: assert property (acc_ack |-> $past(acc_req))
		else $error("ack without request");
	req_spacing_a: assert property (acc_req |=> !acc_req)
		else $error("request while one is outstanding");
	burst_block_a: assert property (refused_p)
		else $error("burst fault read not refused");
	wr_zero_a: assert property (acc_req & acc_write |=> acc_rdata == 8'h00)
		else $error("write answered with data");
	alert_width_a: assert property (alert_w_p)
		else $error("alert pulse width wrong");
	alert_max_a: assert property (low_cnt <= 16'(ALERT_CYCLES))
		else $error("alert pulse too long");
	good_alert_a: assert property (good_alert_p)
		else $error("good change gave no alert");
	cover property ($fell(host_alert_pin_n));
	cover property (fb_rd);
	cover property ($fell(power_good_pin_n));
	cover property (acc_req && acc_write && acc_wdata[CTL_RAISE]);
endmodule

/* testbench.sv */
// bench: device end and host end joined over the link, driven by hand
// assumes shortened alert, blink and step counts to keep the run short
`timescale 1ns/100ps
module testbench import csil_pkg::*; ;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic vbus_in_window = 1'b0;
	logic vbus_above_battery = 1'b0;
	logic vbus_above_min = 1'b0;
	logic type_detect_done = 1'b0;
	logic source_identified = 1'b0;
	logic charging = 1'b0;
	logic charge_done = 1'b0;
	logic charge_suspended = 1'b0;
	logic dpm_active = 1'b0;
	logic [7:0] fault_active = 8'h00;
	logic [5:0] limit_resistor_pin = 6'h3f;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic cmd_burst = 1'b0;
	logic [1:0] cmd_addr = 2'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, alert_event, power_good;
	logic [7:0] rsp_data, rsp_active;
	logic test_load_en, limit_monitor_en, stat_pin_o, stat_pin_oe;
	logic [5:0] applied_limit;
	int failures = 0;
	int check_count = 0;
	int alerts = 0;
	int low_cyc = 0;
	csil_link_if link ();
	csil_device #(.ALERT_CYCLES(8), .BLINK_CYCLES(6), .STEP_CYCLES(4))
		i_csil_device (.clk_sys, .sys_rst, .link, .vbus_in_window,
		.vbus_above_battery, .vbus_above_min, .type_detect_done,
		.source_identified, .charging, .charge_done, .charge_suspended,
		.fault_active, .dpm_active, .limit_resistor_pin, .test_load_en,
		.applied_limit, .limit_monitor_en, .stat_pin_o, .stat_pin_oe);
	csil_host i_csil_host (.clk_sys, .sys_rst, .link, .cmd_valid,
		.cmd_write, .cmd_burst, .cmd_addr, .cmd_wdata, .cmd_ready,
		.rsp_valid, .rsp_data, .rsp_active, .alert_event, .power_good);
	csil_link_monitor #(.ALERT_CYCLES(8)) i_csil_link_monitor (
		.clk_sys, .sys_rst,
		.power_good_pin_n(link.power_good_pin_n),
		.host_alert_pin_n(link.host_alert_pin_n),
		.acc_req(link.acc_req), .acc_write(link.acc_write),
		.acc_burst(link.acc_burst), .acc_addr(link.acc_addr),
		.acc_wdata(link.acc_wdata), .acc_ack(link.acc_ack),
		.acc_rdata(link.acc_rdata));
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	// running tallies so scenarios judge whole pulses, not single edges
	always @(posedge clk_sys) begin
		if (alert_event === 1'b1)
			alerts <= alerts + 1;
		if (applied_limit === LIMIT_100MA)
			low_cyc <= low_cyc + 1;
	end
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		chk(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic cmd(input logic w, input logic [1:0] a,
		input logic [7:0] d, input logic b);
		int n;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_burst <= b;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		for (n = 0; n < 20 && rsp_valid !== 1'b1; n++)
			tick(1);
		chk1("rsp_valid", 1'b1, rsp_valid);
	endtask
	task automatic count_oe(output int k);
		k = 0;
		repeat (24) begin
			tick(1);
			if (stat_pin_oe === 1'b1)
				k++;
		end
	endtask
	task automatic t_limit;
		cmd(1'b0, REG_LIMIT, 8'h00, 1'b0);
		chk("limit_rst", 8'h08, rsp_data);
		cmd(1'b1, REG_LIMIT, 8'h20, 1'b0);
		@(posedge clk_sys);
		limit_resistor_pin <= 6'h05;
		tick(3);
		chk("lim_min", 8'h05, {2'b00, applied_limit});
		chk1("mon_on", 1'b1, limit_monitor_en);
		cmd(1'b1, REG_CTRL, 8'h00, 1'b0);
		tick(3);
		chk("lim_reg", 8'h20, {2'b00, applied_limit});
		chk1("mon_off", 1'b0, limit_monitor_en);
		cmd(1'b1, REG_CTRL, 8'h10, 1'b0);
		cmd(1'b1, REG_LIMIT, 8'h08, 1'b0);
		@(posedge clk_sys);
		limit_resistor_pin <= 6'h3f;
	endtask
	task automatic t_good;
		int a0;
		a0 = alerts;
		@(posedge clk_sys);
		vbus_in_window <= 1'b1;
		vbus_above_battery <= 1'b1;
		type_detect_done <= 1'b1;
		tick(300);
		chk1("load_on", 1'b1, test_load_en);
		chk1("pg_poor", 1'b1, link.power_good_pin_n);
		@(posedge clk_sys);
		vbus_above_min <= 1'b1;
		tick(450);
		chk1("pg_on", 1'b0, link.power_good_pin_n);
		chk1("pg_host", 1'b1, power_good);
		chk1("load_off", 1'b0, test_load_en);
		cmd(1'b0, REG_STATUS, 8'h00, 1'b0);
		chk("good_flag", 8'h03, rsp_data);
		@(posedge clk_sys);
		vbus_above_battery <= 1'b0;
		tick(20);
		chk1("pg_sleep", 1'b1, link.power_good_pin_n);
		chk("pg_alerts", 8'h02, 8'(alerts - a0));
		@(posedge clk_sys);
		vbus_above_battery <= 1'b1;
		tick(20);
	endtask
	task automatic t_stat;
		int k;
		@(posedge clk_sys);
		charging <= 1'b1;
		tick(3);
		chk1("stat_chg", 1'b1, stat_pin_oe);
		chk1("stat_o", 1'b0, stat_pin_o);
		@(posedge clk_sys);
		charging <= 1'b0;
		tick(3);
		chk1("stat_idle", 1'b0, stat_pin_oe);
		@(posedge clk_sys);
		charge_suspended <= 1'b1;
		tick(3);
		count_oe(k);
		chk("blink", 8'h0c, 8'(k));
		cmd(1'b1, REG_CTRL, 8'h18, 1'b0);
		count_oe(k);
		chk("indicator_disable", 8'h00, 8'(k));
		cmd(1'b1, REG_CTRL, 8'h10, 1'b0);
		@(posedge clk_sys);
		charge_suspended <= 1'b0;
	endtask
	task automatic t_events;
		int i;
		int a0;
		for (i = 0; i < 4; i++) begin
			if (i == 3)
				cmd(1'b1, REG_CTRL, 8'h30, 1'b0);
			a0 = alerts;
			@(posedge clk_sys);
			charge_done <= (i == 0);
			source_identified <= (i == 1);
			dpm_active <= (i > 1);
			tick(15);
			chk("event", (i == 3) ? 8'h00 : 8'h01, 8'(alerts - a0));
			@(posedge clk_sys);
			charge_done <= 1'b0;
			source_identified <= 1'b0;
			dpm_active <= 1'b0;
		end
		cmd(1'b1, REG_CTRL, 8'h10, 1'b0);
	endtask
	task automatic t_pump;
		int c0;
		c0 = low_cyc;
		cmd(1'b1, REG_CTRL, 8'h12, 1'b0);
		cmd(1'b0, REG_CTRL, 8'h00, 1'b0);
		chk("busy_up", 8'h13, rsp_data);
		tick(40);
		// the first low phase is one cycle longer: the divider starts late
		chk("low_up", 8'h0d, 8'(low_cyc - c0));
		cmd(1'b0, REG_CTRL, 8'h00, 1'b0);
		chk("done_up", 8'h11, rsp_data);
		chk("lim_up", 8'h08, {2'b00, applied_limit});
		c0 = low_cyc;
		cmd(1'b1, REG_CTRL, 8'h14, 1'b0);
		tick(40);
		chk("low_dn", 8'h09, 8'(low_cyc - c0));
		cmd(1'b0, REG_CTRL, 8'h00, 1'b0);
		chk("done_dn", 8'h11, rsp_data);
		cmd(1'b1, REG_CTRL, 8'h16, 1'b0);
		cmd(1'b0, REG_CTRL, 8'h00, 1'b0);
		chk("both_up", 8'h13, rsp_data);
		tick(40);
		cmd(1'b1, REG_CTRL, 8'h12, 1'b0);
		cmd(1'b1, REG_CTRL, 8'h10, 1'b0);
		c0 = low_cyc;
		tick(1);
		chk("abort_lim", 8'h08, {2'b00, applied_limit});
		tick(30);
		chk("abort_low", 8'h00, 8'(low_cyc - c0));
	endtask
	task automatic t_faults;
		int a0;
		a0 = alerts;
		@(posedge clk_sys);
		fault_active <= 8'h04;
		tick(3);
		@(posedge clk_sys);
		fault_active <= 8'h10;
		tick(3);
		@(posedge clk_sys);
		fault_active <= 8'h00;
		tick(15);
		chk("fault_alerts", 8'h01, 8'(alerts - a0));
		// the host end turns a burst on the fault register into singles
		cmd(1'b0, REG_FAULT, 8'h00, 1'b1);
		chk("burst_rd", 8'h14, rsp_data);
		chk("fault_live", 8'h00, rsp_active);
		cmd(1'b0, REG_FAULT, 8'h00, 1'b0);
		chk("fault_hist", 8'h00, rsp_data);
		@(posedge clk_sys);
		fault_active <= 8'h01;
		tick(15);
		chk("rearm", 8'h02, 8'(alerts - a0));
		cmd(1'b0, REG_FAULT, 8'h00, 1'b0);
		chk("fault_now", 8'h01, rsp_active);
	endtask
	task close_out;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_limit();
		t_good();
		t_stat();
		t_events();
		t_pump();
		t_faults();
		close_out();
	end
	// the whole sequence needs about 1200 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		close_out();
	end
endmodule
